// >>> common/mcms_pkg.sv
// mcms_pkg: register map, field positions, task codes and reset values
// for the modem control, mode and status register bank.
// assumes: 32-bit APB with byte addresses, one aligned word per register.
package mcms_pkg;

  // register byte offsets
  localparam logic [7:0] MCMS_OFS_RX_LOOP_CTRL   = 8'h00;
  localparam logic [7:0] MCMS_OFS_OP_MODE_CFG    = 8'h04;
  localparam logic [7:0] MCMS_OFS_MODEM_STATUS   = 8'h08;
  localparam logic [7:0] MCMS_OFS_TASK_COMMAND   = 8'h0C;

  // receiver_loop_control fields
  localparam int MCMS_CTL_LEVRESP_LO    = 2;
  localparam int MCMS_CTL_LOOPBW_LO     = 0;

  // operating_mode_config fields
  localparam int MCMS_MOD_IRQ_PIN_EN    = 7;
  localparam int MCMS_MOD_BIT_INV       = 6;
  localparam int MCMS_MOD_DIRECTION     = 5;
  localparam int MCMS_MOD_SCRAMBLE_EN   = 4;
  localparam int MCMS_MOD_POWERSAVE     = 3;
  localparam int MCMS_MOD_QUALITY_IRQ   = 2;
  localparam int MCMS_MOD_STRONG_XTAL   = 1;
  localparam int MCMS_MOD_WIDE_FILTER   = 0;

  // modem_status fields
  localparam int MCMS_STA_IRQ           = 7;
  localparam int MCMS_STA_BUF_FREE      = 6;
  localparam int MCMS_STA_IL_EMPTY      = 5;
  localparam int MCMS_STA_OVERFLOW      = 4;
  localparam int MCMS_STA_QUALITY_RDY   = 2;
  localparam int MCMS_STA_PKT_ENV       = 0;

  // task_command fields
  localparam int MCMS_CMD_PKT_END_EN    = 5;
  localparam int MCMS_CMD_ENVELOPE_EN   = 4;
  localparam int MCMS_CMD_TASK_LO       = 0;

  // task codes
  localparam logic [3:0] MCMS_TASK_NULL           = 4'h0;
  localparam logic [3:0] MCMS_TASK_RESET          = 4'h1;
  localparam logic [3:0] MCMS_TASK_SCRAMBLED_OUT  = 4'h2;
  localparam logic [3:0] MCMS_TASK_RX_BLOCK       = 4'h3;
  localparam logic [3:0] MCMS_TASK_RX_SHORT       = 4'h4;
  localparam logic [3:0] MCMS_TASK_TX_SHORT       = 4'h5;
  localparam logic [3:0] MCMS_TASK_TX_BLOCK       = 4'h6;

  // loop settings
  localparam logic [1:0] MCMS_LOOP_HOLD           = 2'h0;
  localparam logic [1:0] MCMS_LEVRESP_ACQUIRE     = 2'h3;
  localparam logic [1:0] MCMS_LOOPBW_ACQUIRE      = 2'h3;

  // reset values
  localparam logic [7:0] MCMS_CTL_RESET           = 8'h00;
  localparam logic [7:0] MCMS_MOD_RESET           = 8'h00;
  localparam logic [5:0] MCMS_CMD_RESET           = 6'h00;

endpackage : mcms_pkg

// >>> rtl/mcms_regs.sv
// mcms_regs: APB register bank with control, mode, status and task command
// registers of a half-duplex packet modem, plus the steering outputs.
// assumes: datapath event inputs are one-cycle pulses synchronous to pclk;
// acquire indications and the detector level are synchronous levels.
`timescale 1ns/10ps
module mcms_regs
  import mcms_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        acquire_level_command,
  input  wire logic        acquire_bit_clock_command,
  input  wire logic        tx_ready_evt,
  input  wire logic        rx_task_done_evt,
  input  wire logic        tx_task_done_evt,
  input  wire logic        interleave_low_evt,
  input  wire logic        quality_done_evt,
  input  wire logic        quality_read_evt,
  input  wire logic        overflow_evt,
  input  wire logic        packet_end_or_envelope_in,
  output logic             interrupt_out_n,
  output logic [1:0]       level_response_select,
  output logic [1:0]       clock_loop_bandwidth,
  output logic             bit_inversion,
  output logic             direction_select,
  output logic             scrambler_run,
  output logic             powersave_bit,
  output logic             strong_crystal_drive,
  output logic             wide_filter_select,
  output logic             bias_feed,
  output logic             task_start,
  output logic [3:0]       task_code,
  output logic             task_abort,
  output logic [1:0]       detect_enable
);

  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  mode;
    logic [5:0]  cmd;
    logic        task_busy;
    logic        irq;
    logic        buf_free;
    logic        il_empty;
    logic        overflow;
    logic        quality_rdy;
    logic        pkt_env;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq_n;
    logic [1:0]  levresp;
    logic [1:0]  loopbw;
    logic        scr_run;
    logic        bias;
    logic        start;
    logic        abort;
  } mcms_state_type;

  mcms_state_type st_r;
  mcms_state_type st_nxt;

  logic       setup;
  logic       acc_wr;
  logic       acc_rd;
  logic       mapped;
  logic [7:0] status_view;
  logic       tx;
  logic       new_tx;
  logic       mode_wr;
  logic       cmd_wr;
  logic [3:0] wr_task;
  logic       mode_change;
  logic       reset_task;
  logic       busy_task;
  logic       quiet_set;
  logic       free_evt;
  logic       empty_evt;
  logic       pe_now;
  logic       pe_edge;
  logic       scr_task;

  always_comb begin
    st_nxt      = st_r;
    setup       = psel && !penable;
    acc_wr      = psel && penable && st_r.pready && pwrite;
    acc_rd      = psel && penable && st_r.pready && !pwrite;
    mapped      = (paddr == MCMS_OFS_RX_LOOP_CTRL) || (paddr == MCMS_OFS_OP_MODE_CFG) ||
                  (paddr == MCMS_OFS_MODEM_STATUS) || (paddr == MCMS_OFS_TASK_COMMAND);
    tx          = st_r.mode[MCMS_MOD_DIRECTION];
    mode_wr     = acc_wr && (paddr == MCMS_OFS_OP_MODE_CFG);
    cmd_wr      = acc_wr && (paddr == MCMS_OFS_TASK_COMMAND);
    wr_task     = pwdata[MCMS_CMD_TASK_LO +: 4];
    new_tx      = mode_wr ? pwdata[MCMS_MOD_DIRECTION] : tx;
    mode_change = mode_wr &&
                  ((pwdata[MCMS_MOD_DIRECTION] != st_r.mode[MCMS_MOD_DIRECTION]) ||
                   (pwdata[MCMS_MOD_POWERSAVE] != st_r.mode[MCMS_MOD_POWERSAVE]));
    reset_task  = cmd_wr && (wr_task == MCMS_TASK_RESET);
    busy_task   = cmd_wr && (wr_task != MCMS_TASK_NULL) && (wr_task != MCMS_TASK_RESET) &&
                  (wr_task != MCMS_TASK_SCRAMBLED_OUT);
    quiet_set   = reset_task || mode_change;

    // status as the host sees it; empty reads zero in receive
    status_view                      = 8'h00;
    status_view[MCMS_STA_IRQ]        = st_r.irq;
    status_view[MCMS_STA_BUF_FREE]   = st_r.buf_free;
    status_view[MCMS_STA_IL_EMPTY]   = st_r.il_empty && tx;
    status_view[MCMS_STA_OVERFLOW]   = st_r.overflow;
    status_view[MCMS_STA_QUALITY_RDY] = st_r.quality_rdy;
    status_view[MCMS_STA_PKT_ENV]    = st_r.pkt_env;

    // bus: ready one cycle after setup, so every access is two cycles
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup && !mapped;
    st_nxt.prdata  = 32'h0000_0000;
    if (setup && !pwrite && (paddr == MCMS_OFS_MODEM_STATUS)) begin
      st_nxt.prdata = {24'h00_0000, status_view};
    end

    // register writes take effect at the access edge
    if (acc_wr && (paddr == MCMS_OFS_RX_LOOP_CTRL)) begin
      st_nxt.ctl = pwdata[7:0];
    end
    if (mode_wr) begin
      st_nxt.mode = pwdata[7:0];
    end
    if (cmd_wr) begin
      st_nxt.cmd = pwdata[5:0];
    end

    // task tracking for scrambler gating and abort
    st_nxt.start = busy_task || (cmd_wr && (wr_task == MCMS_TASK_SCRAMBLED_OUT));
    st_nxt.abort = 1'b0;
    if (tx_task_done_evt || rx_task_done_evt) begin
      st_nxt.task_busy = 1'b0;
    end
    if (st_nxt.start) begin
      st_nxt.task_busy = 1'b1;
    end
    if (reset_task) begin
      st_nxt.task_busy = 1'b0;
    end
    if (mode_wr && (pwdata[MCMS_MOD_DIRECTION] != tx)) begin
      st_nxt.task_busy = 1'b0;
      st_nxt.abort     = st_r.task_busy || st_nxt.start;
      st_nxt.start     = 1'b0;
    end

    // status read clears only what it returned; an event in the setup cycle survives
    if (acc_rd && (paddr == MCMS_OFS_MODEM_STATUS)) begin
      if (st_r.prdata[MCMS_STA_IRQ]) begin
        st_nxt.irq = 1'b0;
      end
      if (st_r.prdata[MCMS_STA_OVERFLOW]) begin
        st_nxt.overflow = 1'b0;
      end
    end

    // buffer free flag
    free_evt = tx ? tx_ready_evt : rx_task_done_evt;
    if (busy_task) begin
      st_nxt.buf_free = 1'b0;
    end
    if (free_evt && !quiet_set) begin
      st_nxt.buf_free = 1'b1;
      if (!st_r.buf_free) begin
        st_nxt.irq = 1'b1;
      end
    end
    if (quiet_set) begin
      st_nxt.buf_free = 1'b1;
    end

    // interleave empty flag, meaningful in transmit only
    empty_evt = tx && interleave_low_evt;
    if (busy_task) begin
      st_nxt.il_empty = 1'b0;
    end
    if (empty_evt && !quiet_set) begin
      st_nxt.il_empty = 1'b1;
      if (!st_r.il_empty) begin
        st_nxt.irq = 1'b1;
      end
    end
    if (quiet_set) begin
      st_nxt.il_empty = 1'b1;
    end

    // quality reading, receive only
    if (quality_read_evt) begin
      st_nxt.quality_rdy = 1'b0;
    end
    if (!tx && quality_done_evt) begin
      st_nxt.quality_rdy = 1'b1;
      if (st_r.mode[MCMS_MOD_QUALITY_IRQ]) begin
        st_nxt.irq = 1'b1;
      end
    end

    // overflow, receive only; reset task and mode change clear it
    if (quiet_set) begin
      st_nxt.overflow = 1'b0;
    end
    if (!tx && overflow_evt && !quiet_set) begin
      st_nxt.overflow = 1'b1;
      if (!st_r.overflow) begin
        st_nxt.irq = 1'b1;
      end
    end
    if (new_tx && !tx) begin
      st_nxt.overflow    = 1'b0;
      st_nxt.quality_rdy = 1'b0;
    end

    // packet end / envelope level, zero in transmit
    pe_now         = !tx && packet_end_or_envelope_in;
    st_nxt.pkt_env = pe_now;
    pe_edge        = 1'b0;
    if (st_r.cmd[MCMS_CMD_PKT_END_EN] && st_r.cmd[MCMS_CMD_ENVELOPE_EN]) begin
      pe_edge = pe_now != st_r.pkt_env;
    end else if (st_r.cmd[MCMS_CMD_PKT_END_EN] || st_r.cmd[MCMS_CMD_ENVELOPE_EN]) begin
      pe_edge = pe_now && !st_r.pkt_env;
    end
    if (pe_edge) begin
      st_nxt.irq = 1'b1;
    end

    // pin follows the next request value so it tracks without lag
    st_nxt.irq_n = !(st_nxt.irq && st_nxt.mode[MCMS_MOD_IRQ_PIN_EN]);

    // loop settings: hold in transmit, overridden while acquiring
    if (st_nxt.mode[MCMS_MOD_DIRECTION]) begin
      st_nxt.levresp = MCMS_LOOP_HOLD;
      st_nxt.loopbw  = MCMS_LOOP_HOLD;
    end else begin
      st_nxt.levresp = acquire_level_command ? MCMS_LEVRESP_ACQUIRE :
                       st_nxt.ctl[MCMS_CTL_LEVRESP_LO +: 2];
      st_nxt.loopbw  = acquire_bit_clock_command ? MCMS_LOOPBW_ACQUIRE :
                       st_nxt.ctl[MCMS_CTL_LOOPBW_LO +: 2];
    end

    // scrambler only inside the scrambling tasks, otherwise held reset
    scr_task = (st_nxt.cmd[MCMS_CMD_TASK_LO +: 4] == MCMS_TASK_SCRAMBLED_OUT) ||
               (st_nxt.cmd[MCMS_CMD_TASK_LO +: 4] == MCMS_TASK_RX_BLOCK) ||
               (st_nxt.cmd[MCMS_CMD_TASK_LO +: 4] == MCMS_TASK_RX_SHORT) ||
               (st_nxt.cmd[MCMS_CMD_TASK_LO +: 4] == MCMS_TASK_TX_SHORT) ||
               (st_nxt.cmd[MCMS_CMD_TASK_LO +: 4] == MCMS_TASK_TX_BLOCK);
    st_nxt.scr_run = st_nxt.mode[MCMS_MOD_SCRAMBLE_EN] && st_nxt.task_busy &&
                     scr_task;

    // mid-level bias while transmit interleave buffer is empty
    st_nxt.bias = st_nxt.mode[MCMS_MOD_DIRECTION] && st_nxt.il_empty;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r             <= '0;
      st_r.ctl         <= MCMS_CTL_RESET;
      st_r.mode        <= MCMS_MOD_RESET;
      st_r.cmd         <= MCMS_CMD_RESET;
      st_r.buf_free    <= 1'b1;
      st_r.il_empty    <= 1'b1;
      st_r.irq_n       <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready                = st_r.pready;
  assign prdata                = st_r.prdata;
  assign pslverr               = st_r.pslverr;
  assign interrupt_out_n       = st_r.irq_n;
  assign level_response_select = st_r.levresp;
  assign clock_loop_bandwidth  = st_r.loopbw;
  assign bit_inversion         = st_r.mode[MCMS_MOD_BIT_INV];
  assign direction_select      = st_r.mode[MCMS_MOD_DIRECTION];
  assign scrambler_run         = st_r.scr_run;
  assign powersave_bit         = st_r.mode[MCMS_MOD_POWERSAVE];
  assign strong_crystal_drive  = st_r.mode[MCMS_MOD_STRONG_XTAL];
  assign wide_filter_select    = st_r.mode[MCMS_MOD_WIDE_FILTER];
  assign bias_feed             = st_r.bias;
  assign task_start            = st_r.start;
  assign task_code             = st_r.cmd[MCMS_CMD_TASK_LO +: 4];
  assign task_abort            = st_r.abort;
  assign detect_enable         = st_r.cmd[MCMS_CMD_PKT_END_EN:MCMS_CMD_ENVELOPE_EN];

endmodule : mcms_regs

// >>> testbench/mcms_regs_checker.sv
// mcms_regs_checker: timing relations of the steering outputs.
// assumes: bound to mcms_regs, single pclk domain.
`timescale 1ns/10ps
module mcms_regs_checker
  import mcms_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       acquire_level_command,
  input wire logic       acquire_bit_clock_command,
  input wire logic [1:0] level_response_select,
  input wire logic [1:0] clock_loop_bandwidth,
  input wire logic       direction_select,
  input wire logic       scrambler_run,
  input wire logic [3:0] task_code,
  input wire logic       task_start,
  input wire logic       task_abort,
  input wire logic       bias_feed
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lev_tx;
    direction_select |-> level_response_select == MCMS_LOOP_HOLD;
  endproperty
  a_lev_tx: assert property (p_lev_tx) else $error("level field live in tx");
  property p_bw_tx;
    direction_select |-> clock_loop_bandwidth == MCMS_LOOP_HOLD;
  endproperty
  a_bw_tx: assert property (p_bw_tx) else $error("bandwidth live in tx");
  property p_lev_acq;
    !direction_select && acquire_level_command ##1 !direction_select
      |-> level_response_select == MCMS_LEVRESP_ACQUIRE;
  endproperty
  a_lev_acq: assert property (p_lev_acq) else $error("level not overridden");
  property p_bw_acq;
    !direction_select && acquire_bit_clock_command ##1 !direction_select
      |-> clock_loop_bandwidth == MCMS_LOOPBW_ACQUIRE;
  endproperty
  a_bw_acq: assert property (p_bw_acq) else $error("bandwidth not overridden");
  property p_scr;
    scrambler_run |-> task_code inside {[MCMS_TASK_SCRAMBLED_OUT:MCMS_TASK_TX_BLOCK]};
  endproperty
  a_scr: assert property (p_scr) else $error("scrambler runs in wrong task");
  property p_abort;
    task_abort |=> !scrambler_run;
  endproperty
  a_abort: assert property (p_abort) else $error("task kept after abort");
  property p_start;
    task_start |-> (task_code != MCMS_TASK_NULL && task_code != MCMS_TASK_RESET)
      ##1 !task_start;
  endproperty
  a_start: assert property (p_start) else $error("bad task start");
  property p_bias;
    !direction_select |-> !bias_feed;
  endproperty
  a_bias: assert property (p_bias) else $error("bias fed in rx");
endmodule : mcms_regs_checker

bind mcms_regs mcms_regs_checker u_chk (
  .pclk, .presetn, .acquire_level_command, .acquire_bit_clock_command,
  .level_response_select, .clock_loop_bandwidth, .direction_select,
  .scrambler_run, .task_code, .task_start, .task_abort, .bias_feed
);

// >>> testbench/mcms_host_model.sv
// mcms_host_model: host microcontroller acting as APB master.
// assumes: tasks are called after presetn has been released.
`timescale 1ns/10ps
module mcms_host_model
  import mcms_pkg::*;
#(
  parameter int BIT_CYC = 4
)
(
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  logic [7:0] mode_r = 8'h00;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hA5;
    pwdata = 32'h5A5A5A5A;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus shows inverted values, not stale ones
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  task automatic set_mode(input logic [7:0] m);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, MCMS_OFS_OP_MODE_CFG, {24'h0, m}, r, e);
    if (m[MCMS_MOD_DIRECTION] && !mode_r[MCMS_MOD_DIRECTION])
      repeat (2 * BIT_CYC) @(posedge pclk);
    mode_r = m;
  endtask : set_mode
endmodule : mcms_host_model

// >>> testbench/tb_top.sv
// tb_top: self-checking bench for mcms_regs with a host model.
// assumes: event inputs are single-cycle pulses, fixed seed.
`timescale 1ns/10ps
module tb_top;
  import mcms_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [6:0]  ev = 7'h00;
  logic        acq_l = 1'b0, acq_b = 1'b0, pe_in = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, interrupt_out_n, rd_e;
  logic        bit_inversion, direction_select, scrambler_run, powersave_bit;
  logic        strong_crystal_drive, wide_filter_select, bias_feed, task_start, task_abort;
  logic [1:0]  level_response_select, clock_loop_bandwidth, detect_enable;
  logic [3:0]  task_code;
  logic [7:0]  paddr, m, c;
  logic [31:0] pwdata, prdata, rd_v, seed_v;
  int          errors = 0, num_checks = 0;

  always #5 pclk = ~pclk;

  mcms_regs uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .acquire_level_command(acq_l), .acquire_bit_clock_command(acq_b),
    .tx_ready_evt(ev[0]), .rx_task_done_evt(ev[1]), .tx_task_done_evt(ev[2]),
    .interleave_low_evt(ev[3]), .quality_done_evt(ev[4]), .quality_read_evt(ev[5]),
    .overflow_evt(ev[6]), .packet_end_or_envelope_in(pe_in), .interrupt_out_n,
    .level_response_select, .clock_loop_bandwidth, .bit_inversion, .direction_select,
    .scrambler_run, .powersave_bit, .strong_crystal_drive, .wide_filter_select, .bias_feed,
    .task_start, .task_code, .task_abort, .detect_enable
  );
  mcms_host_model host (
    .pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr
  );

  function automatic logic [1:0] exp_loop(input logic tx, input logic acq,
                                          input logic [1:0] f, input logic [1:0] a);
    if (tx) return MCMS_LOOP_HOLD;
    return acq ? a : f;
  endfunction : exp_loop
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("FAIL %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, rd_v, rd_e);
  endtask : wr
  task automatic sta(input logic [7:0] x);
    host.xfer(1'b0, MCMS_OFS_MODEM_STATUS, 32'h0, rd_v, rd_e);
    chk("status", {24'h0, x}, rd_v);
  endtask : sta
  task automatic pulse(input int k);
    @(posedge pclk);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev <= 7'h00;
    @(negedge pclk);
  endtask : pulse
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  initial begin
    #200000;
    errors++;
    final_report();
  end

  initial begin
    seed_v = $urandom(32'h0ABC);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("irq_pin", 1, interrupt_out_n);
    sta(8'h40);
    host.xfer(1'b0, 8'h10, 32'h0, rd_v, rd_e);
    chk("slverr", 1, rd_e);
    // random settings, directions and acquire levels
    repeat (12) begin
      m = 8'($urandom) & 8'h6B;
      c = 8'($urandom) & 8'h0F;
      acq_l <= 1'($urandom);
      acq_b <= 1'($urandom);
      wr(MCMS_OFS_RX_LOOP_CTRL, c);
      host.set_mode(m);
      @(negedge pclk);
      chk("lev", exp_loop(m[5], acq_l, c[3:2], MCMS_LEVRESP_ACQUIRE),
          level_response_select);
      chk("bw", exp_loop(m[5], acq_b, c[1:0], MCMS_LOOPBW_ACQUIRE),
          clock_loop_bandwidth);
      chk("mode", {m[6], m[5], m[3], m[1], m[0]}, {bit_inversion, direction_select,
          powersave_bit, strong_crystal_drive, wide_filter_select});
      sta(m[5] ? 8'h60 : 8'h40);
    end
    // every task code in tx with the scrambler enabled
    host.set_mode(8'hB0);
    for (int k = 0; k <= 6; k++) begin
      wr(MCMS_OFS_TASK_COMMAND, {4'h0, MCMS_TASK_RESET});
      wr(MCMS_OFS_TASK_COMMAND, 8'(k));
      @(negedge pclk);
      chk("scr", k >= 2, scrambler_run);
      chk("start", k >= 2, task_start);
      chk("task", k, task_code);
      sta(k > 2 ? 8'h00 : 8'h60);
    end
    pulse(0);
    chk("irq_pin", 0, interrupt_out_n);
    sta(8'hC0);
    @(negedge pclk);
    chk("irq_pin", 1, interrupt_out_n);
    sta(8'h40);
    pulse(3);
    chk("bias", 1, bias_feed);
    sta(8'hE0);
    // direction change in mid-task cancels it
    wr(MCMS_OFS_TASK_COMMAND, {4'h0, MCMS_TASK_TX_BLOCK});
    host.set_mode(8'h90);
    @(negedge pclk);
    chk("abort", 1, task_abort);
    chk("scr", 0, scrambler_run);
    sta(8'h40);
    wr(MCMS_OFS_TASK_COMMAND, {4'h0, MCMS_TASK_RX_BLOCK});
    sta(8'h00);
    pulse(1);
    pulse(6);
    sta(8'hD0);
    sta(8'h40);
    host.set_mode(8'h04);
    pulse(4);
    chk("irq_pin", 1, interrupt_out_n);
    sta(8'hC4);
    pulse(5);
    host.set_mode(8'h24);
    pulse(4);
    sta(8'h60);
    // one detector enable, then both
    host.set_mode(8'h00);
    for (int i = 0; i < 2; i++) begin
      c = i ? 8'h30 : 8'h10;
      wr(MCMS_OFS_TASK_COMMAND, c);
      @(negedge pclk);
      chk("det", c[5:4], detect_enable);
      @(posedge pclk);
      pe_in <= 1'b1;
      repeat (2) @(posedge pclk);
      sta(8'hC1);
      pe_in <= 1'b0;
      repeat (2) @(posedge pclk);
      sta(i ? 8'hC0 : 8'h40);
    end
    // reset in mid-run with a task pending: all returns to idle at once
    wr(MCMS_OFS_TASK_COMMAND, {4'h0, MCMS_TASK_RX_BLOCK});
    sta(8'h00);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk("rst", 8'h01, {detect_enable, task_code, bias_feed, interrupt_out_n});
    @(posedge pclk);
    presetn <= 1'b1;
    sta(8'h40);
    final_report();
  end
endmodule : tb_top
